// ==== rtl/hbd_top.v ====
// Headset button detection and load test with APB register access
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`include "hbd_map.vh"
module hbd_top (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Jack detection status from the detect logic
  input wire jack_detect_done,
  input wire jack_four_pole,
  input wire jack_inserted,
  // Analog front end (asynchronous)
  input wire mic_supply_on,
  input wire [7:0] mic_ratio,
  input wire mic_press_raw,
  input wire [15:0] hp_load_ohm,
  input wire hp_ramp_active,
  // Outputs
  output reg irq,
  output reg measure_req
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  reg [1:0] s1_reg;
  reg [1:0] s2_reg;
  reg [7:0] r1_reg;
  reg [7:0] r2_reg;
  reg [15:0] l1_reg;
  reg [15:0] l2_reg;
  reg p1_reg;
  reg p2_reg;

  // Two flops on every analog front-end input
  // Ratio and load words are settled analog levels; a bit may lag a cycle,
  // so ratio is only used after the press has stood for a whole tick, load only while the ramp runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
      r1_reg <= 8'h00;
      r2_reg <= 8'h00;
      l1_reg <= 16'h0000;
      l2_reg <= 16'h0000;
      p1_reg <= 1'b0;
      p2_reg <= 1'b0;
    end else begin
      s1_reg <= {hp_ramp_active, mic_supply_on};
      s2_reg <= s1_reg;
      r1_reg <= mic_ratio;
      r2_reg <= r1_reg;
      l1_reg <= hp_load_ohm;
      l2_reg <= l1_reg;
      p1_reg <= mic_press_raw;
      p2_reg <= p1_reg;
    end
  end

  wire supply_s = s2_reg[0];
  wire ramp_s = s2_reg[1];

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [31:0] ctrl_reg;
  reg [31:0] thresh_reg;
  reg [8:0] interval_reg;
  reg [7:0] event_reg;
  reg [7:0] enable_reg;
  reg [7:0] btn_sts_reg;
  reg [3:0] held_reg;
  reg any_press_reg;
  reg button_mode_reg;
  reg hp_comp_reg;
  reg hp_valid_reg;
  reg [7:0] ev_set;

  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire [1:0] avg_sel = ctrl_reg[`HBD_CTRL_AVG_LSB +: 2];
  wire hptest_en = ctrl_reg[`HBD_CTRL_HPTEST_EN];
  wire [1:0] res_sel = ctrl_reg[`HBD_CTRL_RES_LSB +: 2];

  // Address decoder for the error response of reads and writes
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `HBD_CTRL) || (a == `HBD_THRESH) ||
               (a == `HBD_INTERVAL) || (a == `HBD_STATUS) ||
               (a == `HBD_EVENT) || (a == `HBD_CLEAR) ||
               (a == `HBD_ENABLE) || (a == `HBD_LOAD);
    end
  endfunction

  // Classify a ratio against the four thresholds
  function [3:0] classify;
    input [7:0] v;
    input [31:0] t;
    begin
      if (v < t[7:0])
        classify = 4'b0001; // A
      else if (v < t[15:8])
        classify = 4'b1000; // D
      else if (v < t[23:16])
        classify = 4'b0010; // B
      else if (v < t[31:24])
        classify = 4'b0100; // C
      else
        classify = 4'b0000; // Microphone, no button
    end
  endfunction

  // Writable control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `HBD_CTRL_RESET;
      thresh_reg <= `HBD_THRESH_RESET;
      interval_reg <= `HBD_INTERVAL_RESET;
      enable_reg <= 8'h00;
    end else if (wr_en) begin
      case (paddr)
        `HBD_CTRL: ctrl_reg <= {27'h0, pwdata[4:0]};
        `HBD_THRESH: thresh_reg <= pwdata;
        `HBD_INTERVAL: begin
          // Clamp nonzero values into the legal range
          if (pwdata[8:0] == 9'h000)
            interval_reg <= 9'h000;
          else if (pwdata[8:0] < `HBD_INTERVAL_MIN)
            interval_reg <= `HBD_INTERVAL_MIN;
          else if (pwdata[8:0] > `HBD_INTERVAL_MAX)
            interval_reg <= `HBD_INTERVAL_MAX;
          else
            interval_reg <= pwdata[8:0];
        end
        `HBD_ENABLE: enable_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Sticky events, set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      event_reg <= 8'h00;
    else if (wr_en && paddr == `HBD_CLEAR)
      event_reg <= (event_reg & ~pwdata[7:0]) | ev_set;
    else
      event_reg <= event_reg | ev_set;
  end

  // APB answer: zero wait states, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `HBD_CTRL: prdata <= ctrl_reg;
          `HBD_THRESH: prdata <= thresh_reg;
          `HBD_INTERVAL: prdata <= {23'h0, interval_reg};
          `HBD_STATUS: prdata <= {18'h0, button_mode_reg, any_press_reg,
                                  held_reg, btn_sts_reg};
          `HBD_EVENT: prdata <= {24'h0, event_reg};
          `HBD_ENABLE: prdata <= {24'h0, enable_reg};
          `HBD_LOAD: prdata <= {30'h0, hp_valid_reg, hp_comp_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Button polling
  // ****************************************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_MEAS = 2'b10;
  localparam ST_HELD = 2'b11;

  reg [1:0] state_reg;
  reg [8:0] ms_cnt_reg;
  reg avg_start;
  wire tick;
  wire avg_done;
  wire [7:0] avg_val;

  hbd_ms_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  hbd_avg u_avg (
    .pclk(pclk),
    .presetn(presetn),
    .start(avg_start),
    .sample_en(tick),
    .sample(r2_reg),
    .avg_sel(avg_sel),
    .done(avg_done),
    .result(avg_val)
  );

  // Poll state machine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      ms_cnt_reg <= 9'h000;
      button_mode_reg <= 1'b0;
      btn_sts_reg <= 8'h00;
      held_reg <= 4'h0;
      any_press_reg <= 1'b0;
      avg_start <= 1'b0;
      measure_req <= 1'b0;
      ev_set <= 8'h00;
    end else begin
      avg_start <= 1'b0;
      ev_set <= 8'h00;
      if (!jack_inserted) begin
        button_mode_reg <= 1'b0;
        state_reg <= ST_IDLE;
        measure_req <= 1'b0;
        held_reg <= 4'h0;
        any_press_reg <= 1'b0;
      end else if (jack_detect_done && jack_four_pole) begin
        button_mode_reg <= 1'b1;
      end
      if (jack_inserted) begin
        case (state_reg)
          ST_IDLE: begin
            // Interval only honoured in button mode
            if (button_mode_reg && interval_reg != 9'h000) begin
              ms_cnt_reg <= interval_reg;
              state_reg <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            if (interval_reg == 9'h000) begin
              state_reg <= ST_IDLE;
            end else if (tick) begin
              if (ms_cnt_reg <= 9'h001) begin
                if (p2_reg && supply_s) begin
                  measure_req <= 1'b1;
                  avg_start <= 1'b1;
                  state_reg <= ST_MEAS;
                end else if (p2_reg) begin
                  // No supply: only a generic press
                  any_press_reg <= 1'b1;
                  held_reg <= 4'h0;
                  state_reg <= ST_HELD;
                end else begin
                  ms_cnt_reg <= interval_reg;
                end
              end else begin
                ms_cnt_reg <= ms_cnt_reg - 9'h001;
              end
            end
          end
          ST_MEAS: begin
            if (avg_done) begin
              measure_req <= 1'b0;
              btn_sts_reg <= avg_val;
              held_reg <= classify(avg_val, thresh_reg);
              ev_set[`HBD_EV_PRESS_LSB +: 4] <=
                classify(avg_val, thresh_reg);
              any_press_reg <= 1'b1;
              state_reg <= ST_HELD;
            end
          end
          ST_HELD: begin
            // Further presses ignored until release
            if (tick && !p2_reg) begin
              ev_set[`HBD_EV_REL_LSB +: 4] <= held_reg;
              held_reg <= 4'h0;
              any_press_reg <= 1'b0;
              ms_cnt_reg <= interval_reg;
              state_reg <= ST_WAIT;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Headphone versus line output test
  // ****************************************************************
  reg [15:0] res_ohm;

  // Threshold select decode
  always @* begin
    case (res_sel)
      2'b00: res_ohm = `HBD_RES_0;
      2'b01: res_ohm = `HBD_RES_1;
      2'b10: res_ohm = `HBD_RES_2;
      default: res_ohm = `HBD_RES_3;
    endcase
  end

  // Compare load against threshold while the ramp runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_comp_reg <= 1'b0;
      hp_valid_reg <= 1'b0;
    end else if (hptest_en && ramp_s) begin
      hp_comp_reg <= (l2_reg < res_ohm);
      hp_valid_reg <= 1'b1;
    end else if (!hptest_en) begin
      hp_valid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  // Enabled events drive the level output; masks leave flags alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(event_reg & enable_reg);
  end

endmodule

// ==== shared/hbd_map.vh ====
// Register map, field positions, reset values and timing counts
// ****************************************************************
// ****************************************************************
`ifndef HBD_MAP_VH
`define HBD_MAP_VH

// Register byte offsets
`define HBD_CTRL 12'h000
`define HBD_THRESH 12'h004
`define HBD_INTERVAL 12'h008
`define HBD_STATUS 12'h00c
`define HBD_EVENT 12'h010
`define HBD_CLEAR 12'h014
`define HBD_ENABLE 12'h018
`define HBD_LOAD 12'h01c

// Control fields
`define HBD_CTRL_AVG_LSB 0
`define HBD_CTRL_HPTEST_EN 2
`define HBD_CTRL_RES_LSB 3
`define HBD_CTRL_RESET 32'h0000_0000

// Threshold reset values, one byte each: A/D, D/B, B/C, C/mic
`define HBD_THRESH_RESET 32'he0_c0_80_40

// Interval field: milliseconds, 9 bits
`define HBD_INTERVAL_RESET 9'h000
`define HBD_INTERVAL_MIN 9'h002
`define HBD_INTERVAL_MAX 9'h1f4

// Event bit positions: press a..d in 3:0, release a..d in 7:4
`define HBD_EV_PRESS_LSB 0
`define HBD_EV_REL_LSB 4

// Timing
`define HBD_CLK_MHZ 100
`define HBD_MS_US 1000
`define HBD_MS_CYCLES (`HBD_CLK_MHZ * `HBD_MS_US)

// Load thresholds in ohms per select code
`define HBD_RES_0 16'd1000
`define HBD_RES_1 16'd2500
`define HBD_RES_2 16'd5000
`define HBD_RES_3 16'd10000

`endif

// ==== rtl/hbd_ms_tick.v ====
// Millisecond enable pulse divider
`timescale 1ns/1ps
`include "hbd_map.vh"
module hbd_ms_tick #(
  parameter MS_CYCLES = `HBD_MS_CYCLES
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Tick out
  output reg tick
);
  // Reload value, cut to the counter width on purpose
  localparam integer LAST_I = MS_CYCLES - 1;
  reg [16:0] cnt_reg;

  // Count down one millisecond, pulse at terminal
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 17'h00000;
      tick <= 1'b0;
    end else if (cnt_reg == 17'h00000) begin
      cnt_reg <= LAST_I[16:0];
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - 17'h00001;
      tick <= 1'b0;
    end
  end
endmodule

// ==== rtl/hbd_avg.v ====
// Accumulator that averages 1, 2, 4 or 8 eight-bit samples
`timescale 1ns/1ps
module hbd_avg (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire start,
  input wire sample_en,
  input wire [7:0] sample,
  input wire [1:0] avg_sel,
  // Result
  output reg done,
  output reg [7:0] result
);
  reg [10:0] sum_reg;
  reg [3:0] left_reg;
  reg busy_reg;
  // Running sum with this sample, and its scaled average
  wire [10:0] sum_new = sum_reg + {3'h0, sample};
  wire [10:0] avg_new = sum_new >> avg_sel;

  // One sample per enable, shift sum by log2 count at the end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_reg <= 11'h000;
      left_reg <= 4'h0;
      busy_reg <= 1'b0;
      done <= 1'b0;
      result <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start) begin
        sum_reg <= 11'h000;
        left_reg <= 4'h1 << avg_sel;
        busy_reg <= 1'b1;
      end else if (busy_reg && sample_en) begin
        if (left_reg == 4'h1) begin
          result <= avg_new[7:0];
          busy_reg <= 1'b0;
          done <= 1'b1;
        end
        sum_reg <= sum_new;
        left_reg <= left_reg - 4'h1;
      end
    end
  end
endmodule

// ==== verification/hbd_checker.sv ====
// Port-level checks for the headset button and load test block
`timescale 1ns/1ps
`include "hbd_map.vh"
module hbd_checker (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Jack and outputs
  input wire jack_inserted,
  input wire irq,
  input wire measure_req
);
  // **********
  // Checks
  // **********
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed write seen at the access edge
  wire acc_w = psel && penable && pwrite && pready;
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  ready_needs_sel_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  err_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 0)
    else $error("unmapped read not zero");
  req_needs_jack_a: assert property (
    $rose(measure_req) |-> $past(jack_inserted))
    else $error("measurement without jack");
  irq_off_enable_a: assert property (acc_w && paddr == `HBD_ENABLE &&
    pwdata[7:0] == 8'h00 |=> ##[0:1] !irq)
    else $error("irq stays up with all disabled");
  irq_off_clear_a: assert property (acc_w && paddr == `HBD_CLEAR &&
    pwdata[7:0] == 8'hff |-> ##[1:2] !irq)
    else $error("irq stays up after clear");
  irq_seen_c: cover property ($rose(irq));
  req_seen_c: cover property ($rose(measure_req));
  err_seen_c: cover property (pslverr);
endmodule
bind hbd_top hbd_checker chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .jack_inserted(jack_inserted), .irq(irq), .measure_req(measure_req));

// ==== verification/hbd_headset.sv ====
// Headset model: button contact on the mic line and its supply
`timescale 1ns/1ps
module hbd_headset (
  // Clock
  input wire pclk,
  // Bench commands
  input wire press_cmd,
  input wire supply_cmd,
  input wire [7:0] ratio_cmd,
  // Mic line toward the block
  output reg mic_press_raw = 1'b0,
  output reg mic_supply_on = 1'b0,
  output reg [7:0] mic_ratio = 8'h5a
);
  // Ratio is meaningful only with a closed contact and the supply on; else it wanders
  always @(posedge pclk) begin
    mic_press_raw <= press_cmd;
    mic_supply_on <= supply_cmd;
    if (press_cmd && supply_cmd) begin
      mic_ratio <= ratio_cmd;
    end else begin
      mic_ratio <= ~mic_ratio;
    end
  end
endmodule

// ==== verification/hbd_tb_top.sv ====
// Self-checking bench for the headset button and load test block
`timescale 1ns/1ps
`include "hbd_map.vh"
module hbd_tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg jdone = 1'b0;
  reg four = 1'b0;
  reg ins = 1'b0;
  reg [15:0] load = 16'h0;
  reg ramp = 1'b0;
  reg press = 1'b0;
  reg supply = 1'b0;
  reg [7:0] ratio = 8'h00;
  wire [31:0] prdata;
  wire pready, pslverr, irq, mreq, raw, sup_on;
  wire [7:0] mratio;
  integer num_errors = 0;
  integer checks_done = 0;
  integer seed = 40;
  integer i;
  reg [31:0] rd;
  reg err;
  reg [3:0] c;
  reg [15:0] th;
  always #5 pclk = ~pclk;
  // Short millisecond so polling and averaging fit in a brief run
  defparam dut.u_tick.MS_CYCLES = 20;
  hbd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .jack_detect_done(jdone), .jack_four_pole(four), .jack_inserted(ins),
    .mic_supply_on(sup_on), .mic_ratio(mratio), .mic_press_raw(raw),
    .hp_load_ohm(load), .hp_ramp_active(ramp), .irq(irq),
    .measure_req(mreq));
  hbd_headset hs (.pclk(pclk), .press_cmd(press), .supply_cmd(supply),
    .ratio_cmd(ratio), .mic_press_raw(raw), .mic_supply_on(sup_on),
    .mic_ratio(mratio));
  // **********
  // Tasks and model
  // **********
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("[ERR] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // One APB transfer; holds until pready is sampled high
  task apb(input [11:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n == 20) chk("pready", 32'h1, 32'h0);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr_rd(input [11:0] a, input [31:0] d, input [31:0] e);
    begin
      apb(a, 1'b1, d);
      apb(a, 1'b0, 32'h0);
      chk("readback", e, rd);
    end
  endtask
  // Poll a register until a bit of the mask shows up
  task wait_rd(input [11:0] a, input [31:0] m);
    integer n;
    begin
      n = 0;
      rd = 32'h0;
      while ((rd & m) == 32'h0 && n < 60) begin
        repeat (100) @(posedge pclk);
        apb(a, 1'b0, 32'h0);
        n = n + 1;
      end
      if (n == 60) chk("wait", m, 32'h0);
    end
  endtask
  // Button class from the reset thresholds, one-hot {D,C,B,A}
  function [3:0] cls(input [7:0] x);
    reg [31:0] t;
    begin
      t = `HBD_THRESH_RESET;
      if (x < t[7:0]) cls = 4'h1;
      else if (x < t[15:8]) cls = 4'h8;
      else if (x < t[23:16]) cls = 4'h2;
      else if (x < t[31:24]) cls = 4'h4;
      else cls = 4'h0;
    end
  endfunction
  // Press, inspect, release one button with given enables and averaging
  task push(input [7:0] val, input [7:0] en, input [1:0] avg);
    begin
      c = cls(val);
      apb(`HBD_CTRL, 1'b1, {30'h0, avg});
      apb(`HBD_ENABLE, 1'b1, {24'h0, en});
      apb(`HBD_CLEAR, 1'b1, 32'h0000_00ff);
      ratio <= val;
      press <= 1'b1;
      wait_rd(`HBD_EVENT, 32'h0000_000f);
      chk("press event", {28'h0, c}, rd);
      chk("measure_req", 32'h0, {31'h0, mreq});
      apb(`HBD_STATUS, 1'b0, 32'h0);
      chk("status value", {24'h0, val}, {24'h0, rd[7:0]});
      chk("status button", {28'h0, c}, {28'h0, rd[11:8]});
      chk("irq", {31'h0, |(en[3:0] & c)}, {31'h0, irq});
      press <= 1'b0;
      wait_rd(`HBD_EVENT, 32'h0000_00f0);
      chk("events", {24'h0, c, c}, rd);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask
  // **********
  // Scenarios
  // **********
  initial begin
    #900000;
    num_errors = num_errors + 1;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      if (i != 5) begin
        apb({i[9:0], 2'b00}, 1'b0, 32'h0);
        chk("reset", (i == 1) ? `HBD_THRESH_RESET : 32'h0, rd);
      end
    end
    apb(12'h020, 1'b1, 32'hffff_ffff);
    apb(12'h020, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    wr_rd(`HBD_INTERVAL, 32'h1, 32'h2);
    wr_rd(`HBD_INTERVAL, 32'h1ff, 32'h1f4);
    rd = $random(seed);
    wr_rd(`HBD_THRESH, rd, rd);
    wr_rd(`HBD_THRESH, `HBD_THRESH_RESET, `HBD_THRESH_RESET);
    load <= 16'h0001;
    ramp <= 1'b1;
    repeat (20) @(posedge pclk);
    ramp <= 1'b0;
    apb(`HBD_LOAD, 1'b0, 32'h0);
    chk("load off", 32'h0, rd);
    // Host order: set up, start the ramp, read the result
    for (i = 0; i < 4; i = i + 1) begin
      rd = $random(seed);
      load <= rd[15:0] & 16'h3fff;
      case (i)
        0: th = `HBD_RES_0;
        1: th = `HBD_RES_1;
        2: th = `HBD_RES_2;
        default: th = `HBD_RES_3;
      endcase
      apb(`HBD_CTRL, 1'b1, {27'h0, i[1:0], 3'b100});
      ramp <= 1'b1;
      repeat (20) @(posedge pclk);
      ramp <= 1'b0;
      repeat (10) @(posedge pclk);
      apb(`HBD_LOAD, 1'b0, 32'h0);
      chk("load", {30'h0, 1'b1, load < th}, rd);
    end
    apb(`HBD_INTERVAL, 1'b1, 32'h2);
    supply <= 1'b1;
    ins <= 1'b1;
    four <= 1'b1;
    jdone <= 1'b1;
    @(posedge pclk);
    jdone <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(`HBD_STATUS, 1'b0, 32'h0);
    chk("button mode", 32'h1, {31'h0, rd[13]});
    rd = $random(seed);
    push(rd[7:0] % 8'he0, 8'hff, 2'b00);
    push(8'h90, 8'h00, 2'b11);
    supply <= 1'b0;
    apb(`HBD_CLEAR, 1'b1, 32'h0000_00ff);
    press <= 1'b1;
    wait_rd(`HBD_STATUS, 32'h0000_1000);
    chk("any press", 32'h1000, rd & 32'h1000);
    repeat (400) @(posedge pclk);
    apb(`HBD_EVENT, 1'b0, 32'h0);
    chk("no event", 32'h0, rd);
    press <= 1'b0;
    repeat (100) @(posedge pclk);
    // Zero interval stops polling: a new press leaves no trace
    apb(`HBD_INTERVAL, 1'b1, 32'h0);
    apb(`HBD_CLEAR, 1'b1, 32'h0000_00ff);
    supply <= 1'b1;
    press <= 1'b1;
    repeat (400) @(posedge pclk);
    apb(`HBD_STATUS, 1'b0, 32'h0);
    chk("idle poll", 32'h0, rd & 32'h1f00);
    apb(`HBD_EVENT, 1'b0, 32'h0);
    chk("idle event", 32'h0, rd);
    // Jack removal drops button mode and held state
    ins <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(`HBD_STATUS, 1'b0, 32'h0);
    chk("removed", 32'h0, rd & 32'h3f00);
    press <= 1'b0;
    wrap_up;
  end
endmodule
